// file: logic/ahrp_pkg.sv
// Package for the asynchronous host register port.
// Assumes a single 100 MHz system clock and a synchronous active-high reset.
package ahrp_pkg;
    // ------------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------------
    localparam int DATA_W       = 8;
    localparam int ADDR_W       = 8;
    localparam int TEST_BIT     = 7;
    localparam int NUM_SRC      = 7;
    localparam int SYNC_STAGES  = 3;

    // Alarm source bit positions
    localparam int SRC_LOS      = 0;
    localparam int SRC_LOF      = 1;
    localparam int SRC_LAIS     = 2;
    localparam int SRC_LRDEF    = 3;
    localparam int SRC_PTRLOSS  = 4;
    localparam int SRC_PAIS     = 5;
    localparam int SRC_PRDEF    = 6;

    // ------------------------------------------------------------------
    // Register map (normal space A7 low, test space A7 high)
    // ------------------------------------------------------------------
    localparam logic [6:0] OFS_IRQ_STAT = 7'h00; // Sticky status, read acknowledges
    localparam logic [6:0] OFS_IRQ_MASK = 7'h01; // Enable per source, 1 = reported
    localparam logic [6:0] OFS_SCRATCH  = 7'h02;
    localparam logic [6:0] OFS_TEST_SCR = 7'h00; // Scratch in test space

    // Reset values
    localparam logic [7:0] RST_MASK     = 8'h00;
    localparam logic [7:0] RST_SCRATCH  = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Strobe edge tracking state
    typedef enum logic [1:0] {
        AH_IDLE  = 2'b00,
        AH_WRITE = 2'b01,
        AH_READ  = 2'b10
    } ahrp_state_e;

    // Synchronised host strobes
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic cs_n;
        logic ale;
    } ahrp_strobe_s;
endpackage

// file: logic/ahrp_sync.sv
// Three-stage synchroniser with agreement filter for one bit.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ps
module ahrp_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Data
    input  wire logic async_i,
    output logic      sync_o
);
    logic [2:0] stage_q;

    // ------------------------------------------------------------------
    // Shift chain; stage 0 only feeds stage 1
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_q <= {3{RESET_VAL}};
        end else begin
            stage_q <= {stage_q[1:0], async_i};
        end
    end

    // Filtered output changes only when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_o <= RESET_VAL;
        end else if (stage_q[1] == stage_q[2]) begin
            sync_o <= stage_q[2];
        end
    end
endmodule

// file: logic/ahrp_port.sv
// Asynchronous 8-bit host register access port with interrupt output.
// Assumes host strobes are slow compared with MCLK_I (several cycles wide).
`timescale 1ns/1ps
import ahrp_pkg::*;
// Functional notes
// - Data bus driven with addressed register while read and select low.
// - Write strobe rising edge with select low stores data bus value.
// - Host address picks which internal register is read or written.
// - Top address bit selects test register space when high.
// - Latch enable high passes address, low holds latched address.
// - Active-low reset releases data bus and interrupt at once; registers clear on the next clock.
// - Interrupt pin pulled low while any unmasked sticky status bit is set.
// - Interrupt pin open drain, released once status read acknowledges.
// - Seven line and path alarm sources, each separately maskable.
module ahrp_port import ahrp_pkg::*; #(
    parameter int NSRC = NUM_SRC
) (
    // Clock and reset
    input  wire logic              MCLK_I,
    input  wire logic              RST_I,
    input  wire logic              ASYNC_RESET_N_I,
    // Host strobes and address
    input  wire logic              READ_STROBE_N_I,
    input  wire logic              WRITE_STROBE_N_I,
    input  wire logic              CHIP_SELECT_N_I,
    input  wire logic              ALE_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    // Data bus, split three ways
    input  wire logic [DATA_W-1:0] DATA_I,
    output logic      [DATA_W-1:0] DATA_O,
    output logic                   DATA_OE_O,
    // Alarm sources from the line logic
    input  wire logic [NSRC-1:0]   ALARM_I,
    // Open-drain interrupt
    output logic                   IRQ_OUT_N_O,
    output logic                   IRQ_OE_O
);
    // ------------------------------------------------------------------
    // Reset combine
    // ------------------------------------------------------------------
    logic         arst_q;
    logic         rst;
    ahrp_strobe_s stb;

    // Pin reset caught asynchronously, released through the clock
    always_ff @(posedge MCLK_I or negedge ASYNC_RESET_N_I) begin
        if (!ASYNC_RESET_N_I) begin
            arst_q <= 1'b1;
        end else begin
            arst_q <= 1'b0;
        end
    end
    assign rst = RST_I | arst_q | !ASYNC_RESET_N_I;

    // ------------------------------------------------------------------
    // Strobe synchronisers
    // ------------------------------------------------------------------
    // Default reset level of one matches every idle pin, so no false edge after reset
    ahrp_sync u_rd (.clk_i(MCLK_I), .rst_i(rst),
        .async_i(READ_STROBE_N_I), .sync_o(stb.rd_n));
    ahrp_sync u_wr (.clk_i(MCLK_I), .rst_i(rst),
        .async_i(WRITE_STROBE_N_I), .sync_o(stb.wr_n));
    ahrp_sync u_cs (.clk_i(MCLK_I), .rst_i(rst),
        .async_i(CHIP_SELECT_N_I), .sync_o(stb.cs_n));
    ahrp_sync u_al (.clk_i(MCLK_I), .rst_i(rst),
        .async_i(ALE_I), .sync_o(stb.ale));

    // ------------------------------------------------------------------
    // Address latch
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] data_s_q;
    logic [ADDR_W-1:0] addr_s_q;

    // Address and data sampled each clock; valid while strobes stand
    always_ff @(posedge MCLK_I) begin
        if (rst) begin
            addr_s_q <= 8'h00;
            data_s_q <= 8'h00;
        end else begin
            addr_s_q <= ADDR_I;
            data_s_q <= DATA_I;
        end
    end

    // Transparent while latch enable high, held while low
    always_ff @(posedge MCLK_I) begin
        if (rst) begin
            addr_q <= 8'h00;
        end else if (stb.ale) begin
            addr_q <= addr_s_q;
        end
    end

    // ------------------------------------------------------------------
    // Access state
    // ------------------------------------------------------------------
    ahrp_state_e state_q;
    ahrp_state_e state_d;
    logic        rd_act;
    logic        wr_act;
    logic        wr_done;
    logic        rd_done;
    logic        test_sel;
    logic [6:0]  reg_ofs;

    assign rd_act   = !stb.rd_n && !stb.cs_n;
    assign wr_act   = !stb.wr_n && !stb.cs_n;
    assign test_sel = addr_q[TEST_BIT];
    assign reg_ofs  = addr_q[6:0];

    // Track which strobe is active so its trailing edge is seen once
    always_comb begin
        state_d = state_q;
        case (state_q)
            AH_IDLE:  state_d = wr_act ? AH_WRITE : (rd_act ? AH_READ : AH_IDLE);
            AH_WRITE: state_d = stb.wr_n ? AH_IDLE : AH_WRITE;
            AH_READ:  state_d = rd_act ? AH_READ : AH_IDLE;
            default:  state_d = AH_IDLE;
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (rst) begin
            state_q <= AH_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Write commits on the rising write strobe, select still low
    assign wr_done = (state_q == AH_WRITE) && stb.wr_n && !stb.cs_n;
    assign rd_done = (state_q == AH_READ) && !rd_act;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] mask_q;
    logic [DATA_W-1:0] scr_q;
    logic [DATA_W-1:0] tscr_q;
    logic [NSRC-1:0]   stat_q;
    logic              stat_rd;

    // Writable registers chosen by space and offset
    always_ff @(posedge MCLK_I) begin
        if (rst) begin
            mask_q <= RST_MASK;
            scr_q  <= RST_SCRATCH;
            tscr_q <= RST_SCRATCH;
        end else if (wr_done) begin
            if (test_sel) begin
                if (reg_ofs == OFS_TEST_SCR) tscr_q <= data_s_q;
            end else begin
                if (reg_ofs == OFS_IRQ_MASK) mask_q <= data_s_q;
                if (reg_ofs == OFS_SCRATCH) scr_q <= data_s_q;
            end
        end
    end

    assign stat_rd = rd_done && !test_sel && (reg_ofs == OFS_IRQ_STAT);

    // Sticky alarm bits; a new alarm wins over the acknowledging read
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_src
            always_ff @(posedge MCLK_I) begin
                if (rst) begin
                    stat_q[g] <= 1'b0;
                end else if (ALARM_I[g]) begin
                    stat_q[g] <= 1'b1;
                end else if (stat_rd) begin
                    stat_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read data and data bus drive
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK_I) begin
        if (rst) begin
            DATA_O <= READ_UNMAPPED;
        end else if (test_sel) begin
            DATA_O <= (reg_ofs == OFS_TEST_SCR) ? tscr_q : READ_UNMAPPED;
        end else begin
            case (reg_ofs)
                OFS_IRQ_STAT: DATA_O <= {{(DATA_W-NSRC){1'b0}}, stat_q};
                OFS_IRQ_MASK: DATA_O <= mask_q;
                OFS_SCRATCH:  DATA_O <= scr_q;
                default:      DATA_O <= READ_UNMAPPED;
            endcase
        end
    end

    // Drive only while read and select both low; released at once on pin reset
    assign DATA_OE_O = rd_act && (state_q == AH_READ) && ASYNC_RESET_N_I;

    // ------------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------------
    logic irq_q;

    // Registered so the pin never glitches on mixed source edges
    always_ff @(posedge MCLK_I) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & mask_q[NSRC-1:0]);
        end
    end
    assign IRQ_OUT_N_O = 1'b0;                            // Open drain only pulls low
    // Pin reset lets go of the line without waiting for a clock edge
    assign IRQ_OE_O    = irq_q && ASYNC_RESET_N_I;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_bus_release: assert property (@(posedge MCLK_I) disable iff (rst)
        (stb.rd_n || stb.cs_n) |-> !DATA_OE_O)
        else $error("data bus driven outside a read");
    chk_irq_follow: assert property (@(posedge MCLK_I) disable iff (rst)
        |(stat_q & mask_q[NSRC-1:0]) |=> IRQ_OE_O)
        else $error("unmasked alarm did not pull interrupt");
    chk_mask_write: assert property (@(posedge MCLK_I) disable iff (rst)
        (wr_done && !test_sel && reg_ofs == OFS_IRQ_MASK) |=> mask_q == $past(data_s_q))
        else $error("mask write not stored");
    chk_ack_clear: assert property (@(posedge MCLK_I) disable iff (rst)
        (stat_rd && !(|ALARM_I)) |=> stat_q == '0)
        else $error("status read did not acknowledge");
    chk_alarm_sticky: assert property (@(posedge MCLK_I) disable iff (rst)
        ALARM_I[SRC_LOS] |=> stat_q[SRC_LOS])
        else $error("alarm not captured");
    chk_latch_hold: assert property (@(posedge MCLK_I) disable iff (rst)
        !stb.ale |=> $stable(addr_q))
        else $error("address changed while latched");
    chk_test_isolate: assert property (@(posedge MCLK_I) disable iff (rst)
        (wr_done && test_sel) |=> $stable(mask_q) && $stable(scr_q))
        else $error("test write reached normal space");
    // Scratch read held over two edges with the address unchanged
    sequence seq_scr_read;
        (rd_act && !test_sel && reg_ofs == OFS_SCRATCH) ##1 (rd_act && $stable(addr_q));
    endsequence
    chk_read_data: assert property (@(posedge MCLK_I) disable iff (rst)
        seq_scr_read |-> DATA_O == $past(scr_q))
        else $error("read data wrong");
    chk_reset_quiet: assert property (@(posedge MCLK_I)
        !ASYNC_RESET_N_I |-> !IRQ_OE_O && !DATA_OE_O)
        else $error("outputs active during pin reset");
endmodule

// file: tb/ahrp_host_model.sv
// Host processor model driving the register port strobes and data bus.
// Assumes a free-running clock; strobes are held well past synchroniser delay.
`timescale 1ns/1ps
module ahrp_host_model import ahrp_pkg::*; (
    // Clock
    input  wire logic              clk_i,
    // Device side of the data bus
    input  wire logic [DATA_W-1:0] dev_data_i,
    input  wire logic              dev_oe_i,
    // Strobes and address
    output logic                   rd_n_o,
    output logic                   wr_n_o,
    output logic                   cs_n_o,
    output logic                   ale_o,
    output logic [ADDR_W-1:0]      addr_o,
    // Resolved bus level
    output logic [DATA_W-1:0]      bus_o
);
    // ------------------------------------------------------------------
    // Bus resolution
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] drv_q;
    logic              drv_en;
    logic [DATA_W-1:0] last_q;

    // Undriven bus toggles so a stale value never passes as read data
    always_comb begin
        bus_o = dev_oe_i ? dev_data_i : (drv_en ? drv_q : ~last_q);
    end
    always @(posedge clk_i) begin
        last_q <= bus_o;
    end

    // Idle levels: select high, latch transparent
    initial begin
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        cs_n_o = 1'b1;
        ale_o  = 1'b1;
        addr_o = 8'h00;
        drv_q  = 8'h00;
        drv_en = 1'b0;
        last_q = 8'h5A;
    end

    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Write; cs=1 makes a deliberately unselected strobe
    task automatic write(input logic [7:0] a, input logic [7:0] d, input logic cs);
        wait_cyc(1);
        addr_o = a;
        drv_q  = d;
        drv_en = 1'b1;
        cs_n_o = cs;
        wr_n_o = 1'b0;
        wait_cyc(8);
        wr_n_o = 1'b1;
        wait_cyc(8);
        cs_n_o = 1'b1;
        drv_en = 1'b0;
        wait_cyc(8);
    endtask

    // Read with strobe and select low throughout; optional latched address
    task automatic read(input logic [7:0] a, input logic latch, output logic [7:0] d,
                        output logic oe);
        wait_cyc(1);
        addr_o = a;
        if (latch) begin
            wait_cyc(8);
            ale_o = 1'b0;
            wait_cyc(8);
            addr_o = ~a;
        end
        cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        wait_cyc(10);
        d  = bus_o;
        oe = dev_oe_i;
        rd_n_o = 1'b1;
        cs_n_o = 1'b1;
        ale_o  = 1'b1;
        wait_cyc(10);
    endtask
endmodule

// file: tb/testbench.sv
// Self-checking testbench for the host register port.
// Assumes the host model file is compiled before this one.
`timescale 1ns/1ps
module testbench;
    import ahrp_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic               MCLK_I;
    logic               RST_I;
    logic               ASYNC_RESET_N_I;
    logic [NUM_SRC-1:0] alarm;
    logic               rd_n, wr_n, cs_n, ale;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  bus, dout;
    logic               doe, irq_n, irq_oe, irq_pin;
    int                 mismatches, samples_checked, cycles;

    // Pull-up on the open-drain interrupt line
    assign irq_pin = irq_oe ? irq_n : 1'b1;

    ahrp_port dut (.MCLK_I(MCLK_I), .RST_I(RST_I), .ASYNC_RESET_N_I(ASYNC_RESET_N_I),
        .READ_STROBE_N_I(rd_n), .WRITE_STROBE_N_I(wr_n), .CHIP_SELECT_N_I(cs_n),
        .ALE_I(ale), .ADDR_I(addr), .DATA_I(bus), .DATA_O(dout), .DATA_OE_O(doe),
        .ALARM_I(alarm), .IRQ_OUT_N_O(irq_n), .IRQ_OE_O(irq_oe));

    ahrp_host_model host (.clk_i(MCLK_I), .dev_data_i(dout), .dev_oe_i(doe),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .cs_n_o(cs_n), .ale_o(ale), .addr_o(addr),
        .bus_o(bus));

    // ------------------------------------------------------------------
    // Clock, timeout and reporting
    // ------------------------------------------------------------------
    initial begin
        MCLK_I = 1'b0;
        forever #5 MCLK_I = ~MCLK_I;
    end

    // Roughly 22 accesses of 21 to 37 cycles each, so 5000 is ample
    always @(posedge MCLK_I) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic latch, input logic [7:0] exp);
        logic [7:0] d;
        logic       oe;
        host.read(a, latch, d, oe);
        check(d, exp);
        check({7'h0, oe}, 8'h01);
        check({7'h0, doe}, 8'h00);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_rw();
        check({7'h0, doe}, 8'h00);
        rd_chk(8'h01, 1'b0, RST_MASK);
        host.write(8'h02, 8'hA5, 1'b0);
        host.write(8'h80, 8'h3C, 1'b0);
        host.write(8'h03, 8'h77, 1'b0);
        host.write(8'h02, 8'h11, 1'b1);
        rd_chk(8'h02, 1'b0, 8'hA5);
        rd_chk(8'h80, 1'b0, 8'h3C);
        rd_chk(8'h82, 1'b0, READ_UNMAPPED);
        rd_chk(8'h03, 1'b0, READ_UNMAPPED);
        rd_chk(8'h02, 1'b1, 8'hA5);
    endtask

    task automatic t_irq();
        host.write(8'h01, 8'h7F, 1'b0);
        for (int i = 0; i < NUM_SRC; i++) begin
            alarm = 7'(1 << i);
            host.wait_cyc(10);
            alarm = '0;
            host.wait_cyc(10);
            check({7'h0, irq_pin}, 8'h00);
            rd_chk(8'h00, 1'b0, 8'(1 << i));
            check({7'h0, irq_pin}, 8'h01);
        end
        host.write(8'h01, 8'h3F, 1'b0);
        alarm = 7'h40;
        host.wait_cyc(20);
        check({7'h0, irq_pin}, 8'h01);
        alarm = 7'h20;
        host.wait_cyc(20);
        check({7'h0, irq_pin}, 8'h00);
        alarm = '0;
    endtask

    task automatic t_async();
        host.write(8'h02, 8'hC3, 1'b0);
        alarm = 7'h01;
        host.wait_cyc(20);
        check({7'h0, irq_pin}, 8'h00);
        ASYNC_RESET_N_I = 1'b0;
        #1 check({7'h0, irq_pin}, 8'h01);
        host.wait_cyc(3);
        ASYNC_RESET_N_I = 1'b1;
        alarm = '0;
        host.wait_cyc(3);
        rd_chk(8'h01, 1'b0, RST_MASK);
        rd_chk(8'h02, 1'b0, RST_SCRATCH);
        check({7'h0, irq_pin}, 8'h01);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        alarm = '0;
        ASYNC_RESET_N_I = 1'b1;
        RST_I = 1'b1;
        repeat (5) @(posedge MCLK_I);
        #1 RST_I = 1'b0;
        t_rw();
        t_irq();
        t_async();
        finish_test();
    end
endmodule
